// File: nvsc_consts.vh
// constants for the host-side controller of the nonvolatile static memory
// assumes a 40 MHz sys_clk; included by nvsc_host.v, nvsc_strobe.v and the memory model
// How it works
// - host keeps address stable through the write
// - host keeps output-drive high during writes
// - six reads ending 70F start store
// - six reads ending 70E start recall
// - sequence steps are select-controlled reads
// - write strobe high for all six steps
// - host never holds a write at power-up recall end
`ifndef NVSC_CONSTS_VH
`define NVSC_CONSTS_VH
`define NVSC_AW 11
`define NVSC_DW 8
`define NVSC_SEQ0 11'h000
`define NVSC_SEQ1 11'h555
`define NVSC_SEQ2 11'h2AA
`define NVSC_SEQ3 11'h7FF
`define NVSC_SEQ4 11'h0F0
`define NVSC_STORE_ADDR 11'h70F
`define NVSC_RECALL_ADDR 11'h70E
`define NVSC_CLK_MHZ 40
// times in their own units
`define NVSC_STORE_MS 10
`define NVSC_RECALL_US 20
`define NVSC_RESTORE_US 550
// access phase lengths in cycles (25 ns each)
`define NVSC_SETUP_CYC 4'h1
`define NVSC_STROBE_CYC 4'h2
`define NVSC_HOLD_CYC 4'h1
// command codes
`define NVSC_CMD_READ 2'h0
`define NVSC_CMD_WRITE 2'h1
`define NVSC_CMD_STORE 2'h2
`define NVSC_CMD_RECALL 2'h3
`endif

// File: nvsc_host.v
// host controller driving the nonvolatile static memory pins
// assumes the memory is synchronous enough to sample within the timed phases
`timescale 1ns/1ps
`include "nvsc_consts.vh"
module nvsc_host #(
    parameter STORE_CYC = `NVSC_STORE_MS * 1000 * `NVSC_CLK_MHZ,
    parameter RESTORE_CYC = `NVSC_RESTORE_US * `NVSC_CLK_MHZ,
    parameter RECALL_CYC = `NVSC_RECALL_US * `NVSC_CLK_MHZ
) (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // user command
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire [10:0] cmd_addr,
    input wire [7:0] cmd_wdata,
    output reg cmd_ready,
    output reg rsp_valid,
    output reg [7:0] rsp_rdata,
    output reg busy,
    // memory pins
    output reg chip_select_n,
    output reg write_strobe_n,
    output reg output_drive_n,
    output reg [10:0] address_lines,
    input wire [7:0] data_lines_in,
    output reg [7:0] data_lines_out,
    output reg data_lines_oe
);
    localparam H_BOOT = 3'h0;
    localparam H_IDLE = 3'h1;
    localparam H_ACC = 3'h2;
    localparam H_WAIT = 3'h3;
    localparam H_DONE = 3'h4;
    localparam CW = 32;

    function [10:0] seq_addr;
        input [2:0] idx;
        input rec;
        begin
            case (idx)
                3'h0: seq_addr = `NVSC_SEQ0;
                3'h1: seq_addr = `NVSC_SEQ1;
                3'h2: seq_addr = `NVSC_SEQ2;
                3'h3: seq_addr = `NVSC_SEQ3;
                3'h4: seq_addr = `NVSC_SEQ4;
                default: seq_addr = rec ? `NVSC_RECALL_ADDR : `NVSC_STORE_ADDR;
            endcase
        end
    endfunction

    reg [2:0] state;
    reg [1:0] op;
    reg [2:0] step;
    reg [CW-1:0] wait_cnt;
    reg acc_go;
    wire sel_active;
    wire strobe_phase;
    wire acc_last;
    wire is_wr = (op == `NVSC_CMD_WRITE);
    wire is_seq = (op == `NVSC_CMD_STORE) || (op == `NVSC_CMD_RECALL);

    nvsc_strobe u_strobe (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .go(acc_go),
        .is_write(is_wr),
        .sel_active(sel_active),
        .strobe_phase(strobe_phase),
        .last(acc_last)
    );

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            // pins idle high so no write is pending when power-up recall ends
            state <= H_BOOT;
            wait_cnt <= RESTORE_CYC[CW-1:0];
            op <= `NVSC_CMD_READ;
            step <= 3'h0;
            acc_go <= 1'b0;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 8'h00;
            busy <= 1'b1;
            chip_select_n <= 1'b1;
            write_strobe_n <= 1'b1;
            output_drive_n <= 1'b1;
            address_lines <= 11'h000;
            data_lines_out <= 8'h00;
            data_lines_oe <= 1'b0;
        end else begin
            acc_go <= 1'b0;
            rsp_valid <= 1'b0;
            // select is the controlling strobe; write strobe never falls in sequences
            chip_select_n <= ~sel_active;
            write_strobe_n <= ~(sel_active & is_wr);
            // output drive stays high for writes and sequence steps
            output_drive_n <= ~(strobe_phase & ~is_wr & ~is_seq);
            case (state)
                H_BOOT: begin
                    if (wait_cnt == {CW{1'b0}}) begin
                        state <= H_IDLE;
                        busy <= 1'b0;
                        cmd_ready <= 1'b1;
                    end else begin
                        wait_cnt <= wait_cnt - 1'b1;
                    end
                end
                H_IDLE: begin
                    if (cmd_valid) begin
                        cmd_ready <= 1'b0;
                        busy <= 1'b1;
                        op <= cmd_op;
                        step <= 3'h0;
                        // sequences begin at the first fixed address
                        if (cmd_op == `NVSC_CMD_STORE || cmd_op == `NVSC_CMD_RECALL)
                            address_lines <= seq_addr(3'h0, cmd_op == `NVSC_CMD_RECALL);
                        else
                            address_lines <= cmd_addr;
                        data_lines_out <= cmd_wdata;
                        data_lines_oe <= (cmd_op == `NVSC_CMD_WRITE);
                        acc_go <= 1'b1;
                        state <= H_ACC;
                    end
                end
                H_ACC: begin
                    // address and data frozen for the whole access
                    if (strobe_phase && !is_wr && !is_seq)
                        rsp_rdata <= data_lines_in;
                    if (acc_last) begin
                        data_lines_oe <= 1'b0;
                        if (is_seq && step != 3'h5) begin
                            // next step immediately, nothing intervenes
                            step <= step + 3'h1;
                            address_lines <= seq_addr(step + 3'h1, op == `NVSC_CMD_RECALL);
                            acc_go <= 1'b1;
                        end else if (is_seq) begin
                            // device busy: store erases/programs, recall clears/copies
                            wait_cnt <= (op == `NVSC_CMD_STORE) ?
                                STORE_CYC[CW-1:0] : RECALL_CYC[CW-1:0];
                            state <= H_WAIT;
                        end else begin
                            state <= H_DONE;
                        end
                    end
                end
                H_WAIT: begin
                    if (wait_cnt == {CW{1'b0}})
                        state <= H_DONE;
                    else
                        wait_cnt <= wait_cnt - 1'b1;
                end
                H_DONE: begin
                    rsp_valid <= 1'b1;
                    busy <= 1'b0;
                    cmd_ready <= 1'b1;
                    state <= H_IDLE;
                end
                default: state <= H_IDLE;
            endcase
        end
    end
endmodule

// File: nvsc_host_props.sv
// assertions on the pin and command ports of nvsc_host
// assumes the bench runs nvsc_host with RESTORE_CYC of at least 8
`timescale 1ns/1ps
module nvsc_host_props (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // command side
    input wire cmd_valid,
    input wire [1:0] cmd_op,
    input wire cmd_ready,
    input wire rsp_valid,
    input wire busy,
    // memory pins
    input wire chip_select_n,
    input wire write_strobe_n,
    input wire output_drive_n,
    input wire [10:0] address_lines,
    input wire [7:0] data_lines_out,
    input wire data_lines_oe
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    wire take = cmd_valid && cmd_ready;
    rw_latency_a: assert property (take && !cmd_op[1] |-> ##8 rsp_valid)
        else $error("read or write answer not on time");
    write_pins_a: assert property (!write_strobe_n |-> !chip_select_n && output_drive_n && data_lines_oe)
        else $error("write strobe without select or with output drive");
    read_pins_a: assert property (!output_drive_n |-> !chip_select_n && write_strobe_n && !data_lines_oe)
        else $error("bad read strobes");
    addr_hold_a: assert property (!chip_select_n && !$past(chip_select_n) |->
        $stable(address_lines) && $stable(data_lines_out))
        else $error("address or data moved in access");
    strobe_width_a: assert property ($fell(chip_select_n) |=> !chip_select_n ##1 chip_select_n)
        else $error("select pulse not two cycles");
    boot_wait_a: assert property ($fell(sys_rst) |-> (busy && !cmd_ready && write_strobe_n) [*8])
        else $error("command taken during restore");
    seq_reads_a: assert property (take && cmd_op[1] |-> (write_strobe_n && output_drive_n) [*8])
        else $error("sequence step not a plain read");
    seq_addr_a: assert property (take && cmd_op[1] |-> ##4 !chip_select_n && address_lines == 11'h000
        ##6 !chip_select_n && address_lines == 11'h555)
        else $error("sequence addresses wrong");
    cover property (take && cmd_op == 2'h1);
    cover property (take && cmd_op == 2'h2);
    cover property (take && cmd_op == 2'h3);
endmodule
bind nvsc_host nvsc_host_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .busy(busy),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
    .address_lines(address_lines), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe));

// File: nvsc_mem_model.sv
// behavioural model of the nonvolatile static memory
// assumes pins change only just after sys_clk edges
`timescale 1ns/1ps
`include "nvsc_consts.vh"
module nvsc_mem_model #(parameter BUSY_CYC = 8) (
    // clock
    input wire sys_clk,
    // pins
    input wire chip_select_n,
    input wire write_strobe_n,
    input wire output_drive_n,
    input wire [10:0] address_lines,
    input wire [7:0] data_lines,
    output wire [7:0] q
);
    reg [7:0] mem [0:2047];
    reg [7:0] sh [0:2047];
    reg [7:0] last_q = 8'h00;
    reg [2:0] step = 3'h0;
    reg cs_q = 1'b1;
    reg wr_q = 1'b0;
    reg [10:0] a_q;
    reg [7:0] d_q;
    integer idle = 0;
    integer i;
    wire wr = !chip_select_n && !write_strobe_n;
    wire [10:0] want = step == 0 ? `NVSC_SEQ0 : step == 1 ? `NVSC_SEQ1 : step == 2 ? `NVSC_SEQ2 :
        step == 3 ? `NVSC_SEQ3 : `NVSC_SEQ4;
    // released bus shows inverted last value so stale data cannot pass
    assign q = (!chip_select_n && !output_drive_n && write_strobe_n && idle == 0) ?
        mem[address_lines] : ~last_q;
    initial begin
        for (i = 0; i < 2048; i = i + 1) begin
            sh[i] = i[7:0] ^ 8'h5A;
            mem[i] = sh[i];
        end
    end
    always @(posedge sys_clk) begin
        last_q <= q;
        cs_q <= chip_select_n;
        wr_q <= wr;
        a_q <= address_lines;
        d_q <= data_lines;
        if (idle != 0) begin
            idle <= idle - 1;
        end else begin
            if (wr_q && !wr) mem[a_q] <= d_q;
            if (cs_q && !chip_select_n) begin
                if (!write_strobe_n) begin
                    step <= 3'h0;
                end else if (step == 5 && address_lines == `NVSC_STORE_ADDR) begin
                    for (i = 0; i < 2048; i = i + 1) sh[i] <= mem[i];
                    idle <= BUSY_CYC;
                    step <= 3'h0;
                end else if (step == 5 && address_lines == `NVSC_RECALL_ADDR) begin
                    for (i = 0; i < 2048; i = i + 1) mem[i] <= sh[i];
                    idle <= BUSY_CYC;
                    step <= 3'h0;
                end else if (step < 5 && address_lines == want) begin
                    step <= step + 3'h1;
                end else begin
                    step <= address_lines == `NVSC_SEQ0 ? 3'h1 : 3'h0;
                end
            end
        end
    end
endmodule

// File: nvsc_strobe.v
// one timed access on the memory pins: setup, strobe, hold
// assumes pins are registered by the caller's clock domain
`timescale 1ns/1ps
`include "nvsc_consts.vh"
module nvsc_strobe (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // request
    input wire go,
    input wire is_write,
    // phase outputs
    output reg sel_active,
    output reg strobe_phase,
    output reg last
);
    localparam S_IDLE = 2'h0;
    localparam S_SETUP = 2'h1;
    localparam S_STROBE = 2'h2;
    localparam S_HOLD = 2'h3;
    reg [1:0] state;
    reg [3:0] cnt;
    reg wr;
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= S_IDLE;
            cnt <= 4'h0;
            wr <= 1'b0;
            sel_active <= 1'b0;
            strobe_phase <= 1'b0;
            last <= 1'b0;
        end else begin
            last <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (go) begin
                        wr <= is_write;
                        state <= S_SETUP;
                        cnt <= `NVSC_SETUP_CYC;
                    end
                end
                S_SETUP: begin
                    // address settles before any strobe falls
                    if (cnt == 4'h1) begin
                        state <= S_STROBE;
                        cnt <= `NVSC_STROBE_CYC;
                        sel_active <= 1'b1;
                        strobe_phase <= 1'b1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_STROBE: begin
                    if (cnt == 4'h1) begin
                        // select and the other strobes rise on the same edge, which ends the access
                        state <= S_HOLD;
                        cnt <= `NVSC_HOLD_CYC;
                        sel_active <= 1'b0;
                        strobe_phase <= 1'b0;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                S_HOLD: begin
                    // address and data held past the end of the access
                    if (cnt == 4'h1) begin
                        state <= S_IDLE;
                        last <= 1'b1;
                    end else begin
                        cnt <= cnt - 4'h1;
                    end
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// File: tb.sv
// self-checking bench for nvsc_host against the memory model
// assumes shortened store, restore and recall waits
`timescale 1ns/1ps
`define CHK(a, b) begin compares = compares + 1; if ((a) !== (b)) begin failures = failures + 1; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module tb;
    reg sys_clk = 0;
    reg sys_rst = 1;
    reg cmd_valid = 0;
    reg [1:0] cmd_op = 0;
    reg [10:0] cmd_addr = 0;
    reg [7:0] cmd_wdata = 0;
    wire cmd_ready, rsp_valid, busy, chip_select_n, write_strobe_n, output_drive_n, data_lines_oe;
    wire [7:0] rsp_rdata, data_lines_in, data_lines_out;
    wire [10:0] address_lines;
    integer failures = 0, compares = 0, i, k;
    reg [7:0] ref_mem [0:2047];
    reg [7:0] ref_sh [0:2047];
    reg [31:0] seed = 32'h76ED4DED;
    reg [10:0] al [0:7];
    nvsc_host #(.STORE_CYC(20), .RESTORE_CYC(10), .RECALL_CYC(10)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
        .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(busy),
        .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n),
        .address_lines(address_lines), .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
        .data_lines_oe(data_lines_oe));
    nvsc_mem_model #(.BUSY_CYC(8)) mdl (.sys_clk(sys_clk), .chip_select_n(chip_select_n),
        .write_strobe_n(write_strobe_n), .output_drive_n(output_drive_n), .address_lines(address_lines),
        .data_lines(data_lines_oe ? data_lines_out : ~data_lines_in), .q(data_lines_in));
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task give_verdict;
        begin
            $display("compares %0d failures %0d", compares, failures);
            if (failures == 0 && compares > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task do_cmd(input [1:0] op, input [10:0] a, input [7:0] d);
        integer n;
        begin
            n = 0;
            @(negedge sys_clk);
            while (cmd_ready !== 1'b1 && n < 100) begin @(negedge sys_clk); n = n + 1; end
            cmd_op = op;
            cmd_addr = a;
            cmd_wdata = d;
            cmd_valid = 1;
            @(negedge sys_clk);
            cmd_valid = 0;
            n = 0;
            while (rsp_valid !== 1'b1 && n < 200) begin @(negedge sys_clk); n = n + 1; end
            `CHK(rsp_valid, 1'b1)
            if (op == 1) ref_mem[a] = d;
            for (n = 0; n < 2048; n = n + 1) begin
                if (op == 2) ref_sh[n] = ref_mem[n];
                if (op == 3) ref_mem[n] = ref_sh[n];
            end
        end
    endtask
    task rd_all;
        for (i = 0; i < 8; i = i + 1) begin do_cmd(0, al[i], 0); `CHK(rsp_rdata, ref_mem[al[i]]) end
    endtask
    initial forever #12.5 sys_clk = ~sys_clk;
    initial begin #(25 * 20000); failures = failures + 1; give_verdict; end
    initial begin
        for (i = 0; i < 2048; i = i + 1) begin ref_sh[i] = i[7:0] ^ 8'h5A; ref_mem[i] = ref_sh[i]; end
        for (i = 0; i < 8; i = i + 1) begin seed = lfsr(seed); al[i] = i == 0 ? 11'h7FF : seed[10:0]; end
        repeat (5) @(negedge sys_clk);
        sys_rst = 0;
        do_cmd(0, al[1], 0);
        `CHK(rsp_rdata, ref_mem[al[1]])
        for (k = 0; k < 2; k = k + 1) begin
            for (i = 0; i < 8; i = i + 1) begin seed = lfsr(seed); do_cmd(1, al[i], seed[7:0]); end
            rd_all;
            if (k == 0) do_cmd(2, 0, 0);
        end
        do_cmd(3, 0, 0);
        rd_all;
        do_cmd(3, 0, 0);
        rd_all;
        give_verdict;
    end
endmodule
